// ==== design/dspcm_pkg.sv ====
package dspcm_pkg;

  // Register word indices on the plain register port
  localparam logic [3:0] CLOCK_MODE_REG_ADDR = 4'h0;
  localparam logic [3:0] BUS_CONTROL_REG_ADDR = 4'h1;
  localparam logic [3:0] STATUS_REG_ADDR = 4'h2;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;

  // Clock mode register fields
  localparam int CMR_PLL_EN_POS = 0;
  localparam int CMR_FRAC_POS = 1;
  localparam int CMR_INT_POS = 3;
  localparam logic [3:0] CMR_INT_RESET = 4'h1;
  localparam logic [1:0] CMR_FRAC_RESET = 2'h0;

  // Bus control register field
  localparam int OUT_DIV_POS = 0;
  localparam logic [1:0] OUT_DIV_NONE = 2'h0;
  localparam logic [1:0] OUT_DIV_RESET = 2'h3;

  // Status register fields
  localparam int STS_LOCKED_POS = 0;
  localparam int STS_PLL_SRC_POS = 1;
  localparam int STS_DIV4_POS = 2;
  localparam int STS_PINS_POS = 3;

  // Mode pin codes, pin 3 in the top bit
  localparam logic [2:0] PINS_DIV2_A = 3'h0;
  localparam logic [2:0] PINS_DIV4 = 3'h5;
  localparam logic [2:0] PINS_DIV2_B = 3'h7;

  // Lock time
  localparam int SYS_CLK_KHZ = 125000;
  localparam int LOCK_TIME_MS = 30;
  localparam int LOCK_CYCLES = LOCK_TIME_MS * SYS_CLK_KHZ;

  localparam int PERIOD_W = 12;

  typedef enum logic [1:0] {
    DSPCM_SRC_DIV2,
    DSPCM_SRC_DIV4,
    DSPCM_SRC_PLL
  } dspcm_src_e;

  typedef enum logic [1:0] {
    DSPCM_PLL_OFF,
    DSPCM_PLL_LOCKING,
    DSPCM_PLL_LOCKED
  } dspcm_pll_e;

  typedef struct packed {
    logic [3:0] mult_int;
    logic [1:0] mult_frac;
    logic pll_en;
  } dspcm_cmr_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic wr;
    logic rd;
  } dspcm_bus_s;

  function automatic logic [5:0] dspcm_mult_q(input dspcm_cmr_s c);
    logic [5:0] q;
    q = {c.mult_int, c.mult_frac};
    if (c.mult_int == 4'h0) begin
      q = 6'h04;
    end
    return q;
  endfunction

endpackage

// ==== design/dspcm_rate_gen.sv ====
`timescale 1ns/10ps
// Emits one pulse per machine clock edge (two per machine cycle)
module dspcm_rate_gen (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic ref_edge_i,
  input wire dspcm_pkg::dspcm_src_e src_i,
  input wire logic [5:0] mult_q_i,
  input wire logic [dspcm_pkg::PERIOD_W-1:0] period_i,
  output logic edge_o
);

  typedef struct packed {
    dspcm_pkg::dspcm_src_e src;
    logic half;
    logic [dspcm_pkg::PERIOD_W+2:0] acc;
    logic edge_p;
  } dspcm_rg_s;

  dspcm_rg_s r;
  dspcm_rg_s next_r;

  always_comb begin
    logic [dspcm_pkg::PERIOD_W+2:0] sum;
    logic [dspcm_pkg::PERIOD_W+2:0] thresh;
    sum = '0;
    thresh = {1'b0, period_i, 2'b00};
    next_r = r;
    next_r.edge_p = 1'b0;
    next_r.src = src_i;
    if (src_i != r.src) begin
      next_r.acc = '0;
      next_r.half = 1'b0;
    end else begin
      unique case (src_i)
        dspcm_pkg::DSPCM_SRC_DIV2: begin
          next_r.edge_p = ref_edge_i;
        end
        dspcm_pkg::DSPCM_SRC_DIV4: begin
          if (ref_edge_i) begin
            next_r.half = ~r.half;
            next_r.edge_p = r.half;
          end
        end
        dspcm_pkg::DSPCM_SRC_PLL: begin
          // 2N edges per reference period, N in quarters
          sum = r.acc + {{(dspcm_pkg::PERIOD_W-4){1'b0}}, mult_q_i, 1'b0};
          if (period_i != '0 && sum >= thresh) begin
            next_r.acc = sum - thresh;
            next_r.edge_p = 1'b1;
          end else begin
            next_r.acc = sum;
          end
        end
        default: begin
          next_r.edge_p = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '{src: dspcm_pkg::DSPCM_SRC_DIV2, half: 1'b0, acc: '0,
             edge_p: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign edge_o = r.edge_p;

endmodule

// ==== design/dspcm_top.sv ====
`timescale 1ns/10ps
module dspcm_top #(
  parameter int unsigned LOCK_CYCLES = dspcm_pkg::LOCK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic reference_clock_input_i,
  input wire logic mode_select_pin_1_i,
  input wire logic mode_select_pin_2_i,
  input wire logic mode_select_pin_3_i,
  input wire logic [dspcm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dspcm_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [dspcm_pkg::DATA_W-1:0] rd_data_o,
  output logic machine_edge_o,
  output logic machine_clock_output_o,
  output logic pll_locked_o
);

  typedef struct packed {
    logic [2:0] pins_s1;
    logic [2:0] pins_s2;
    logic ref_s1;
    logic ref_s2;
    logic ref_d;
    logic [1:0] strap_cnt;
    logic [2:0] pins;
    logic strap_div4;
    dspcm_pkg::dspcm_cmr_s cmr;
    logic [1:0] out_div;
    dspcm_pkg::dspcm_pll_e pll;
    logic [31:0] lock_cnt;
    logic [dspcm_pkg::PERIOD_W-1:0] per_cnt;
    logic [dspcm_pkg::PERIOD_W-1:0] period;
    logic [1:0] out_cnt;
    logic clk_out;
    logic locked;
    logic [dspcm_pkg::DATA_W-1:0] rd_data;
  } dspcm_st_s;

  dspcm_st_s s;
  dspcm_st_s next_s;
  dspcm_pkg::dspcm_bus_s bus;
  dspcm_pkg::dspcm_src_e src;
  logic ref_edge;
  logic mach_edge;

  // Clock mode register word to fields and back
  function automatic dspcm_pkg::dspcm_cmr_s dspcm_cmr_unpack(
    input logic [dspcm_pkg::DATA_W-1:0] w
  );
    dspcm_pkg::dspcm_cmr_s c;
    c.pll_en = w[dspcm_pkg::CMR_PLL_EN_POS];
    c.mult_frac = w[dspcm_pkg::CMR_FRAC_POS +: 2];
    c.mult_int = w[dspcm_pkg::CMR_INT_POS +: 4];
    return c;
  endfunction

  function automatic logic [dspcm_pkg::DATA_W-1:0] dspcm_cmr_pack(
    input dspcm_pkg::dspcm_cmr_s c
  );
    logic [dspcm_pkg::DATA_W-1:0] w;
    w = '0;
    w[dspcm_pkg::CMR_PLL_EN_POS] = c.pll_en;
    w[dspcm_pkg::CMR_FRAC_POS +: 2] = c.mult_frac;
    w[dspcm_pkg::CMR_INT_POS +: 4] = c.mult_int;
    return w;
  endfunction

  assign bus = '{addr: addr_i, wr_data: wr_data_i, wr: wr_i, rd: rd_i};
  // No edge until the sync stages hold real pin samples
  assign ref_edge = s.ref_s2 & ~s.ref_d & (s.strap_cnt == 2'h3);

  always_comb begin
    if (s.locked) begin
      src = dspcm_pkg::DSPCM_SRC_PLL;
    end else if (s.strap_div4) begin
      src = dspcm_pkg::DSPCM_SRC_DIV4;
    end else begin
      src = dspcm_pkg::DSPCM_SRC_DIV2;
    end
  end

  dspcm_rate_gen u_rate_gen (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .ref_edge_i(ref_edge),
    .src_i(src),
    .mult_q_i(dspcm_pkg::dspcm_mult_q(s.cmr)),
    .period_i(s.period),
    .edge_o(mach_edge)
  );

  always_comb begin
    dspcm_pkg::dspcm_cmr_s wcmr;
    logic [dspcm_pkg::DATA_W-1:0] rv;
    wcmr = '0;
    rv = '0;
    next_s = s;
    next_s.pins_s1 = {mode_select_pin_3_i, mode_select_pin_2_i,
                      mode_select_pin_1_i};
    next_s.pins_s2 = s.pins_s1;
    next_s.ref_s1 = reference_clock_input_i;
    next_s.ref_s2 = s.ref_s1;
    next_s.ref_d = s.ref_s2;

    // Straps caught once the sync stages hold real pin samples
    if (s.strap_cnt != 2'h3) begin
      next_s.strap_cnt = s.strap_cnt + 2'h1;
      next_s.pins = s.pins_s2;
      next_s.strap_div4 = (s.pins_s2 == dspcm_pkg::PINS_DIV4);
    end

    // Reference period in system cycles, saturating
    if (ref_edge) begin
      next_s.period = s.per_cnt;
      next_s.per_cnt = {{(dspcm_pkg::PERIOD_W-1){1'b0}}, 1'b1};
    end else if (s.per_cnt != '1) begin
      next_s.per_cnt = s.per_cnt + 1'b1;
    end

    // Lock sequencing
    unique case (s.pll)
      dspcm_pkg::DSPCM_PLL_OFF: begin
        next_s.lock_cnt = '0;
      end
      dspcm_pkg::DSPCM_PLL_LOCKING: begin
        if (s.lock_cnt >= LOCK_CYCLES - 1) begin
          next_s.pll = dspcm_pkg::DSPCM_PLL_LOCKED;
        end else begin
          next_s.lock_cnt = s.lock_cnt + 32'h1;
        end
      end
      dspcm_pkg::DSPCM_PLL_LOCKED: begin
        next_s.lock_cnt = '0;
      end
      default: begin
        next_s.pll = dspcm_pkg::DSPCM_PLL_OFF;
      end
    endcase

    // Register writes
    if (bus.wr) begin
      unique case (bus.addr)
        dspcm_pkg::CLOCK_MODE_REG_ADDR: begin
          wcmr = dspcm_cmr_unpack(bus.wr_data);
          next_s.cmr = wcmr;
          next_s.lock_cnt = '0;
          if (wcmr.pll_en) begin
            next_s.pll = dspcm_pkg::DSPCM_PLL_LOCKING;
          end else begin
            next_s.pll = dspcm_pkg::DSPCM_PLL_OFF;
          end
        end
        dspcm_pkg::BUS_CONTROL_REG_ADDR: begin
          next_s.out_div = bus.wr_data[dspcm_pkg::OUT_DIV_POS +: 2];
        end
        default: begin
          next_s.out_div = s.out_div;
        end
      endcase
    end

    // Register reads, data valid one cycle later only
    if (bus.rd) begin
      unique case (bus.addr)
        dspcm_pkg::CLOCK_MODE_REG_ADDR: begin
          rv = dspcm_cmr_pack(s.cmr);
        end
        dspcm_pkg::BUS_CONTROL_REG_ADDR: begin
          rv[dspcm_pkg::OUT_DIV_POS +: 2] = s.out_div;
        end
        dspcm_pkg::STATUS_REG_ADDR: begin
          rv[dspcm_pkg::STS_LOCKED_POS] = s.locked;
          rv[dspcm_pkg::STS_PLL_SRC_POS] = (src == dspcm_pkg::DSPCM_SRC_PLL);
          rv[dspcm_pkg::STS_DIV4_POS] = s.strap_div4;
          rv[dspcm_pkg::STS_PINS_POS +: 3] = s.pins;
        end
        default: begin
          rv = '0;
        end
      endcase
    end
    next_s.rd_data = rv;

    // Clock output pin: toggles every (out_div + 1) machine edges
    if (mach_edge) begin
      if (s.out_div == dspcm_pkg::OUT_DIV_NONE ||
          s.out_cnt >= s.out_div) begin
        next_s.clk_out = ~s.clk_out;
        next_s.out_cnt = 2'h0;
      end else begin
        next_s.out_cnt = s.out_cnt + 2'h1;
      end
    end

    // Lock flag kept in a flop so the output leaves a register
    next_s.locked = (next_s.pll == dspcm_pkg::DSPCM_PLL_LOCKED);
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.cmr <= '{mult_int: dspcm_pkg::CMR_INT_RESET,
                 mult_frac: dspcm_pkg::CMR_FRAC_RESET, pll_en: 1'b0};
      s.out_div <= dspcm_pkg::OUT_DIV_RESET;
      s.pll <= dspcm_pkg::DSPCM_PLL_OFF;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_o = s.rd_data;
  assign machine_edge_o = mach_edge;
  assign machine_clock_output_o = s.clk_out;
  assign pll_locked_o = s.locked;

endmodule

// ==== bench/dspcm_ref_osc.sv ====
`timescale 1ns/10ps
// Free-running reference oscillator, 10 MHz by default
module dspcm_ref_osc #(
  parameter realtime HALF = 50.0
) (
  output logic ref_o
);
  initial begin
    ref_o = 1'b0;
    #3.3;
    forever #HALF ref_o = ~ref_o;
  end
endmodule

// ==== bench/dspcm_props.sv ====
`timescale 1ns/10ps
module dspcm_props #(
  parameter int unsigned LOCK_CYCLES = 20
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rd_data_o,
  input wire logic machine_edge_o,
  input wire logic machine_clock_output_o,
  input wire logic pll_locked_o
);
  logic en;
  logic ok;
  logic [1:0] dv;
  logic [3:0] ec;
  int unsigned lc;
  wire cw = wr_i && addr_i == 4'h0;
  wire dw = wr_i && addr_i == 4'h1;
  // Edges since last output toggle; ok is true from reset, drops on a divider write until the next toggle
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en <= 1'b0;
      ok <= 1'b1;
      dv <= 2'h3;
      ec <= 4'h0;
      lc <= 0;
    end else begin
      if (cw) begin
        en <= wr_data_i[0];
      end
      if (dw) begin
        dv <= wr_data_i[1:0];
      end
      ok <= !dw && (ok || $changed(machine_clock_output_o));
      ec <= ($changed(machine_clock_output_o) ? 4'h0 : ec)
        + {3'h0, machine_edge_o};
      lc <= cw ? 0 : (en && !pll_locked_o ? lc + 1 : lc);
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_cfg;
    wr_i && addr_i == 4'h0;
  endsequence
  sequence s_off;
    s_cfg ##0 !wr_data_i[0];
  endsequence
  a_rd_idle_zero: assert property (!rd_i |=> rd_data_o == 16'h0000)
    else $error("read data not zero outside read");
  a_rd_unmapped: assert property (rd_i && addr_i > 4'h2 |=>
    rd_data_o == 16'h0000) else $error("unmapped read not zero");
  a_cfg_unlocks: assert property (s_cfg |=> !pll_locked_o)
    else $error("lock held over reprogram");
  a_off_stays_low: assert property (s_off |=> !pll_locked_o [*4])
    else $error("lock with pll off");
  a_lock_bound: assert property (lc <= LOCK_CYCLES + 4)
    else $error("lock too late");
  a_lock_cause: assert property ($rose(pll_locked_o) |-> en)
    else $error("lock without enable");
  a_div_slow: assert property (machine_edge_o && !pll_locked_o
    |=> !machine_edge_o || pll_locked_o) else $error("fast before lock");
  a_out_ratio: assert property ($changed(machine_clock_output_o) && ok
    |-> ec == {2'h0, dv} + 4'h1) else $error("clock out ratio wrong");
endmodule

bind dspcm_top dspcm_props #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (
  .ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i),
  .addr_i(addr_i),
  .wr_data_i(wr_data_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rd_data_o(rd_data_o),
  .machine_edge_o(machine_edge_o),
  .machine_clock_output_o(machine_clock_output_o),
  .pll_locked_o(pll_locked_o)
);

// ==== bench/dsp_clock_mode_generator_tb.sv ====
`timescale 1ns/10ps
`define CHK(w, e, a) begin n_compared++; if ((a) !== (e)) begin \
  miscompares++; $display("BAD %s exp %0h got %0h", w, e, a); end end
module dsp_clock_mode_generator_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] pins = 3'h0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic [15:0] rdo;
  logic [15:0] v;
  logic edg, co, lk, refc;
  int miscompares = 0;
  int n_compared = 0;
  int e, t;
  initial forever #4 clk = ~clk;
  dspcm_ref_osc u_osc (.ref_o(refc));
  dspcm_top #(.LOCK_CYCLES(20)) u_dut (.ref_clk_i(clk), .reset_n_i(rst_n),
    .reference_clock_input_i(refc), .mode_select_pin_1_i(pins[0]),
    .mode_select_pin_2_i(pins[1]), .mode_select_pin_3_i(pins[2]),
    .addr_i(addr), .wr_data_i(wd), .wr_i(wr), .rd_i(rd), .rd_data_o(rdo),
    .machine_edge_o(edg), .machine_clock_output_o(co), .pll_locked_o(lk));
  function automatic logic near(input int a, input int b);
    return a >= b - b / 16 - 2 && a <= b + b / 16 + 2;
  endfunction
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdo;
  endtask
  // 500 cycles is 40 reference periods
  task automatic cnt();
    logic p;
    e = 0;
    t = 0;
    p = co;
    repeat (500) begin
      @(posedge clk);
      #1;
      e += int'(edg);
      t += int'(co && !p);
      p = co;
    end
  endtask
  task automatic strap(input logic [2:0] p);
    int x;
    @(posedge clk);
    rst_n <= 1'b0;
    pins <= p;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    x = (p == dspcm_pkg::PINS_DIV4) ? 20 : 40;
    rreg(4'h0);
    `CHK("cfg", 16'h0008, v)
    rreg(4'h1);
    `CHK("busctl", 16'h0003, v)
    rreg(4'h2);
    `CHK("status", {10'h000, p, p == dspcm_pkg::PINS_DIV4, 2'h0}, v)
    cnt();
    `CHK("edges", 1'b1, near(e, x))
    `CHK("out4", 1'b1, near(t, x / 8))
    wreg(4'h1, 16'h0000);
    cnt();
    `CHK("out1", 1'b1, near(t, x / 2))
    wreg(4'hF, 16'hFFFF);
    rreg(4'hF);
    `CHK("unmapped", 16'h0000, v)
  endtask
  task automatic pll(input logic [3:0] n, input logic [1:0] f);
    wreg(4'h0, {9'h000, n, f, 1'b1});
    #1;
    `CHK("locking", 1'b0, lk)
    for (int i = 0; i < 200 && !lk; i++) @(posedge clk);
    `CHK("locked", 1'b1, lk)
    rreg(4'h2);
    `CHK("pll src", 2'h3, v[1:0])
    rreg(4'h0);
    `CHK("cfg pll", {9'h000, n, f, 1'b1}, v)
    cnt();
    `CHK("pll edges", 1'b1, near(e, 80 * n + 20 * f))
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    miscompares++;
    stop_test();
  end
  initial begin
    strap(dspcm_pkg::PINS_DIV2_B);
    strap(dspcm_pkg::PINS_DIV4);
    strap(dspcm_pkg::PINS_DIV2_A);
    pll(4'h1, 2'h0);
    pll(4'h3, 2'h0);
    pll(4'h2, 2'h2);
    pll(4'h1, 2'h1);
    pll(4'h1, 2'h3);
    pll(4'h6, 2'h0);
    wreg(4'h0, 16'h0018);
    cnt();
    `CHK("off lock", 1'b0, lk)
    `CHK("off edges", 1'b1, near(e, 40))
    wreg(4'h1, 16'h0001);
    cnt();
    `CHK("out2", 1'b1, near(t, 10))
    wreg(4'h1, 16'h0002);
    cnt();
    `CHK("out3", 1'b1, near(t, 6))
    stop_test();
  end
endmodule
